/* File: bench/mmsr_regs_tb_top.sv */
`timescale 1ns/100ps
module mmsr_regs_tb_top;
   import mmsr_pkg::*;
   logic        core_clk, reset_n, soft_reset, stopped, susp, start_req;
   logic        reload, cfg_valid, pil, avs_read, avs_write;
   logic [15:0] cfg_data, sta_hi, ia_lo, ia_hi;
   logic [7:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [3:0]  avs_byteenable;
   mmsr_init_t  init_block;
   mmsr_frame_t frame_info;
   logic        avs_waitrequest, cfg_mem_req, fdx_test, protect_head;
   logic        force_coll, append_fcs, tx_on, rx_on;
   mmsr_mode_t  mode;
   mmsr_loop_t  loop_mode;
   logic [4:0]  tx_limit;
   int          num_errors, cmp_count, i;
   // ------------------------------------------------------------
   // tables: {mode, port loop in, loop mode, forced collision}
   // and {mode, frame info, append fcs}
   // ------------------------------------------------------------
   logic [19:0] lp_tab [6] = '{20'h01543, 20'h01044, 20'h01000,
                               20'h0180A, 20'h01944, 20'h01800};
   logic [23:0] fc_tab [4] = '{24'h010001, 24'h010800, 24'h0108C1, 24'h010831};

   mmsr_regs DUT (.CORE_CLK(core_clk), .RESET_N(reset_n), .SOFT_RESET(soft_reset),
      .STOPPED(stopped), .SUSPENDED_STATE(susp), .START_REQUEST(start_req),
      .CONFIG_MEMORY_RELOAD(reload), .CFG_MEM_VALID(cfg_valid), .CFG_MEM_DATA(cfg_data),
      .INIT_BLOCK(init_block), .FRAME_INFO(frame_info), .PORT_INTERNAL_LOOP(pil),
      .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
      .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
      .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
      .CFG_MEM_REQ(cfg_mem_req), .STATION_ADDRESS_HIGH(sta_hi), .MODE(mode),
      .INIT_ADDR_LOW(ia_lo), .INIT_ADDR_HIGH(ia_hi), .LOOP_MODE(loop_mode),
      .FULL_DUPLEX_TEST(fdx_test), .TX_ATTEMPT_LIMIT(tx_limit),
      .TX_PROTECT_HEAD(protect_head), .FORCE_COLLISION(force_coll),
      .APPEND_FCS(append_fcs), .TRANSMITTER_ON(tx_on), .RECEIVER_ON(rx_on));

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic wrap_up;
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask : tick

   // request held until waitrequest is seen low; data taken at that edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 40);
      q = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, avs_waitrequest, 1'b0);
         wrap_up();
      end
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(q, exp);
   endtask : rd

   initial begin
      reset_n = 1'b0; soft_reset = 1'b0; stopped = 1'b1; susp = 1'b0;
      start_req = 1'b0; reload = 1'b0; cfg_valid = 1'b0; cfg_data = 16'h0;
      pil = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = 8'h0;
      avs_writedata = 32'h0; avs_byteenable = 4'hF; init_block = '0; frame_info = '0;
      num_errors = 0; cmp_count = 0;
      tick(6);
      chk(mode, 32'h0);
      chk(tx_limit, ATTEMPTS_RTRY);
      chk(append_fcs, 32'h1);
      chk(cfg_mem_req, 32'h1);
      reset_n <= 1'b1;
      tick(3);
      chk(cfg_mem_req, 32'h0);
      cfg_data <= 16'hA5C3;
      cfg_valid <= 1'b1;
      tick(1);
      cfg_valid <= 1'b0;
      tick(2);
      chk(sta_hi, 32'hA5C3);
      rd(OFS_STA_HI, 32'h0000A5C3);
      reload <= 1'b1;
      tick(1);
      reload <= 1'b0;
      tick(1);
      chk(cfg_mem_req, 32'h1);
      tick(1);
      chk(cfg_mem_req, 32'h0);
      $display("test config memory done");
      wr(OFS_MODE, 32'h0000E1FF);
      rd(OFS_MODE, 32'h0000E1FF);
      chk(tx_limit, ATTEMPTS_ONE);
      chk(protect_head, 32'h0);
      wr(OFS_STA_HI, 32'h00005A5A);
      soft_reset <= 1'b1;
      tick(1);
      soft_reset <= 1'b0;
      rd(OFS_MODE, 32'h0000A07B);
      rd(OFS_STA_HI, 32'h00005A5A);
      $display("test soft reset done");
      stopped <= 1'b0;
      wr(OFS_MODE, 32'h00000180);
      rd(OFS_MODE, 32'h0);
      susp <= 1'b1;
      rd(OFS_MODE, 32'h0000A07B);
      wr(OFS_MODE, 32'h00002180);
      rd(OFS_MODE, 32'h00002180);
      susp <= 1'b0;
      stopped <= 1'b1;
      reset_n <= 1'b0;
      tick(2);
      reset_n <= 1'b1;
      rd(OFS_STA_HI, 32'h00005A5A);
      rd(OFS_MODE, 32'h0);
      $display("test access and hard reset done");
      wr(OFS_IADR_LO, 32'h0000BEEF);
      wr(OFS_IADR_HI, 32'h00001357);
      rd(OFS_IADR_LO, 32'h0000BEEF);
      rd(OFS_IADR_HI, 32'h00001357);
      chk(ia_lo, 32'hBEEF);
      chk(ia_hi, 32'h1357);
      avs_byteenable <= 4'h2;
      wr(OFS_IADR_LO, 32'h00001200);
      avs_byteenable <= 4'hF;
      rd(OFS_IADR_LO, 32'h000012EF);
      for (i = 0; i < 6; i++) begin
         pil <= lp_tab[i][3];
         wr(OFS_MODE, {16'h0, lp_tab[i][19:4]});
         tick(3);
         chk(loop_mode, lp_tab[i][2:1]);
         chk(force_coll, lp_tab[i][0]);
         chk(fdx_test, lp_tab[i][6]);
      end
      pil <= 1'b0;
      for (i = 0; i < 4; i++) begin
         frame_info <= fc_tab[i][7:4];
         wr(OFS_MODE, {16'h0, fc_tab[i][23:8]});
         tick(3);
         chk(append_fcs, fc_tab[i][0]);
      end
      $display("test loop and fcs done");
      for (i = 0; i < 2; i++) begin
         wr(OFS_MODE, 32'h180 | (32'h2 >> i));
         stopped <= 1'b0;
         start_req <= 1'b1;
         tick(1);
         start_req <= 1'b0;
         tick(2);
         chk(tx_on, 32'(i));
         chk(rx_on, 32'(1 - i));
         stopped <= 1'b1;
         tick(2);
         chk(tx_on | rx_on, 32'h0);
      end
      init_block <= {1'b1, 16'h1234, 16'h8181};
      tick(1);
      init_block.load <= 1'b0;
      tick(3);
      chk(sta_hi, 32'h1234);
      chk(mode, 32'h8181);
      $display("test start and init load done");
      wrap_up();
   end
endmodule : mmsr_regs_tb_top

/* File: logic/mmsr_regs.sv */
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps
module mmsr_regs (
   input  wire logic                 CORE_CLK,
   input  wire logic                 RESET_N,
   input  wire logic                 SOFT_RESET,
   input  wire logic                 STOPPED,
   input  wire logic                 SUSPENDED_STATE,
   input  wire logic                 START_REQUEST,
   input  wire logic                 CONFIG_MEMORY_RELOAD,
   input  wire logic                 CFG_MEM_VALID,
   input  wire logic [15:0]          CFG_MEM_DATA,
   input  wire mmsr_pkg::mmsr_init_t INIT_BLOCK,
   input  wire mmsr_pkg::mmsr_frame_t FRAME_INFO,
   input  wire logic                 PORT_INTERNAL_LOOP,
   input  wire logic [7:0]           AVS_ADDRESS,
   input  wire logic                 AVS_READ,
   input  wire logic                 AVS_WRITE,
   input  wire logic [31:0]          AVS_WRITEDATA,
   input  wire logic [3:0]           AVS_BYTEENABLE,
   output logic [31:0]               AVS_READDATA,
   output logic                      AVS_WAITREQUEST,
   output logic                      CFG_MEM_REQ,
   output logic [15:0]               STATION_ADDRESS_HIGH,
   output mmsr_pkg::mmsr_mode_t      MODE,
   output logic [15:0]               INIT_ADDR_LOW,
   output logic [15:0]               INIT_ADDR_HIGH,
   output mmsr_pkg::mmsr_loop_t      LOOP_MODE,
   output logic                      FULL_DUPLEX_TEST,
   output logic [4:0]                TX_ATTEMPT_LIMIT,
   output logic                      TX_PROTECT_HEAD,
   output logic                      FORCE_COLLISION,
   output logic                      APPEND_FCS,
   output logic                      TRANSMITTER_ON,
   output logic                      RECEIVER_ON
);
   import mmsr_pkg::*;

   // ----------------------------------------------------------
   // decode and bus handshake
   // ----------------------------------------------------------
   function automatic logic [2:0] reg_sel(input logic [7:0] a);
      if (a == OFS_STA_HI) begin
         reg_sel = 3'h1;
      end else if (a == OFS_MODE) begin
         reg_sel = 3'h2;
      end else if (a == OFS_IADR_LO) begin
         reg_sel = 3'h3;
      end else if (a == OFS_IADR_HI) begin
         reg_sel = 3'h4;
      end else begin
         reg_sel = 3'h0;
      end
   endfunction : reg_sel

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
      merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction : merge

   logic [15:0] station_r;
   mmsr_mode_t  mode_r;
   logic [15:0] iadr_lo_r;
   logic [15:0] iadr_hi_r;
   logic        wait_r;
   logic [31:0] rdata_r;
   logic        req_pend_r;
   logic        access_ok;
   logic        wr_commit;
   logic [2:0]  sel;

   assign access_ok = STOPPED | SUSPENDED_STATE;                            // RL5
   assign sel       = reg_sel(AVS_ADDRESS);
   assign wr_commit = AVS_WRITE & ~wait_r & access_ok;                      // RL22

   // waitrequest drops for one cycle, one edge after the request appears
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         wait_r <= 1'b1;
      end else if ((AVS_READ | AVS_WRITE) & wait_r) begin
         wait_r <= 1'b0;
      end else begin
         wait_r <= 1'b1;
      end
   end

   // unmapped or locked-out reads return zero; reserved bits read zero
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rdata_r <= 32'h0000_0000;
      end else if (AVS_READ & wait_r) begin
         if (!access_ok) begin
            rdata_r <= 32'h0000_0000;                                       // RL5
         end else if (sel == 3'h1) begin
            rdata_r <= {16'h0000, station_r};
         end else if (sel == 3'h2) begin
            rdata_r <= {16'h0000, mode_r & MODE_WR_MASK};                   // RL21
         end else if (sel == 3'h3) begin
            rdata_r <= {16'h0000, iadr_lo_r};
         end else if (sel == 3'h4) begin
            rdata_r <= {16'h0000, iadr_hi_r};
         end else begin
            rdata_r <= 32'h0000_0000;
         end
      end
   end

   // ----------------------------------------------------------
   // station address: no reset at all, so it survives every reset
   // ----------------------------------------------------------
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         req_pend_r <= 1'b1;
      end else begin
         req_pend_r <= CONFIG_MEMORY_RELOAD;                                // RL1
      end
   end

   assign CFG_MEM_REQ = req_pend_r;

   // without a config memory no valid ever arrives and the word stays unknown
   always_ff @(posedge CORE_CLK) begin
      if (CFG_MEM_VALID) begin
         station_r <= CFG_MEM_DATA;                                         // RL1 RL2
      end else if (INIT_BLOCK.load) begin
         station_r <= INIT_BLOCK.station_high;                              // RL3
      end else if (wr_commit && sel == 3'h1) begin
         station_r <= merge(station_r, AVS_WRITEDATA, AVS_BYTEENABLE);      // RL3 RL4
      end
   end

   // ----------------------------------------------------------
   // mode register
   // ----------------------------------------------------------
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         mode_r <= MODE_RST;
      end else if (SOFT_RESET) begin
         mode_r <= mode_r & ~MODE_SRST_CLR;                                 // RL8 RL10 RL15
      end else if (INIT_BLOCK.load) begin
         mode_r <= INIT_BLOCK.mode & MODE_WR_MASK;                          // RL6
      end else if (wr_commit && sel == 3'h2) begin
         mode_r <= merge(mode_r, AVS_WRITEDATA, AVS_BYTEENABLE) & MODE_WR_MASK; // RL6 RL21
      end
   end

   // ----------------------------------------------------------
   // init block address, one storage shared with the primary registers
   // ----------------------------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (wr_commit && sel == 3'h3) begin
         iadr_lo_r <= merge(iadr_lo_r, AVS_WRITEDATA, AVS_BYTEENABLE);      // RL19
      end
      if (wr_commit && sel == 3'h4) begin
         iadr_hi_r <= merge(iadr_hi_r, AVS_WRITEDATA, AVS_BYTEENABLE);      // RL20
      end
   end

   // ----------------------------------------------------------
   // derived controls for the datapaths
   // ----------------------------------------------------------
   mmsr_loop_t loop_nxt;
   always_comb begin
      loop_nxt = MMSR_LOOP_NORMAL;
      if (mode_r.port_selection == PORT_SERIAL) begin
         if (mode_r.loopback & mode_r.internal_loop & ~PORT_INTERNAL_LOOP) begin
            loop_nxt = MMSR_LOOP_INTERNAL;                                  // RL16
         end else if (mode_r.loopback & ~mode_r.internal_loop & ~PORT_INTERNAL_LOOP) begin
            loop_nxt = MMSR_LOOP_EXTERNAL;                                  // RL16
         end
      end else if (mode_r.port_selection == PORT_MII) begin
         if (~mode_r.loopback & ~mode_r.internal_loop & PORT_INTERNAL_LOOP) begin
            loop_nxt = MMSR_LOOP_INTERNAL;                                  // RL16
         end else if (mode_r.loopback & ~mode_r.internal_loop & ~PORT_INTERNAL_LOOP) begin
            loop_nxt = MMSR_LOOP_EXTERNAL;                                  // RL16
         end
      end
   end

   logic fcs_nxt;
   assign fcs_nxt = ~mode_r.fcs_suppress                                    // RL13
                  | (FRAME_INFO.descriptor_fcs_request & FRAME_INFO.end_of_packet_flag)
                  | (FRAME_INFO.auto_transmit_pad & FRAME_INFO.short_frame); // RL14

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         LOOP_MODE        <= MMSR_LOOP_NORMAL;
         FULL_DUPLEX_TEST <= 1'b0;
         TX_ATTEMPT_LIMIT <= ATTEMPTS_RTRY;
         TX_PROTECT_HEAD  <= 1'b1;
         FORCE_COLLISION  <= 1'b0;
         APPEND_FCS       <= 1'b1;
      end else begin
         LOOP_MODE        <= loop_nxt;
         FULL_DUPLEX_TEST <= mode_r.loopback;                               // RL15
         TX_ATTEMPT_LIMIT <= mode_r.no_retry ? ATTEMPTS_ONE : ATTEMPTS_RTRY; // RL11
         TX_PROTECT_HEAD  <= ~mode_r.no_retry;                              // RL11
         FORCE_COLLISION  <= mode_r.forced_collision
                             & (loop_nxt == MMSR_LOOP_INTERNAL);            // RL12
         APPEND_FCS       <= fcs_nxt;
      end
   end

   // running flags: stop clears them, start sets them unless disabled
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         TRANSMITTER_ON <= 1'b0;
         RECEIVER_ON    <= 1'b0;
      end else if (STOPPED | SOFT_RESET) begin
         TRANSMITTER_ON <= 1'b0;
         RECEIVER_ON    <= 1'b0;
      end else if (START_REQUEST) begin
         TRANSMITTER_ON <= ~mode_r.transmit_disable;                        // RL17
         RECEIVER_ON    <= ~mode_r.receive_disable;                         // RL18
      end
   end

   assign AVS_READDATA         = rdata_r;
   assign AVS_WAITREQUEST      = wait_r;
   assign STATION_ADDRESS_HIGH = station_r;
   assign MODE                 = mode_r;                                    // RL7 RL9
   assign INIT_ADDR_LOW        = iadr_lo_r;
   assign INIT_ADDR_HIGH       = iadr_hi_r;

   // ----------------------------------------------------------
   // checks
   // ----------------------------------------------------------
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);

   wr_locked_a: assert property (AVS_WRITE && !wait_r && !access_ok && !SOFT_RESET // RL22
      && !INIT_BLOCK.load |=> $stable(mode_r))
      else $error("mode changed by locked-out write");
   rd_locked_a: assert property (AVS_READ && wait_r && !access_ok         // RL5
      |=> AVS_READDATA == 32'h0000_0000)
      else $error("read returned data while running");
   sta_load_a: assert property (CFG_MEM_VALID                              // RL1
      |=> STATION_ADDRESS_HIGH == $past(CFG_MEM_DATA))
      else $error("station word not loaded from config memory");
   sta_keep_a: assert property (SOFT_RESET && !CFG_MEM_VALID && !INIT_BLOCK.load // RL4
      && !AVS_WRITE |=> $stable(station_r))
      else $error("station word disturbed by soft reset");
   init_load_a: assert property (INIT_BLOCK.load && !SOFT_RESET           // RL6
      |=> MODE == ($past(INIT_BLOCK.mode) & MODE_WR_MASK))
      else $error("mode not loaded from init block");
   srst_clr_a: assert property (SOFT_RESET |=> !MODE.broadcast_reject     // RL8
      && MODE.port_selection == 2'h0 && !MODE.loopback)
      else $error("soft reset left a cleared field set");
   retry_lim_a: assert property (mode_r.no_retry ##1 mode_r.no_retry      // RL11
      |-> TX_ATTEMPT_LIMIT == 5'h01 && !TX_PROTECT_HEAD)
      else $error("attempt limit wrong with no_retry");
   forced_collision_a: assert property (FORCE_COLLISION |-> $past(loop_nxt) == MMSR_LOOP_INTERNAL) // RL12
      else $error("collision forced outside internal loop");
   fcs_pad_a: assert property (FRAME_INFO.auto_transmit_pad && FRAME_INFO.short_frame // RL14
      |=> APPEND_FCS)
      else $error("short padded frame lost its FCS");
   loop_dec_a: assert property (mode_r.port_selection == PORT_MII && PORT_INTERNAL_LOOP // RL16
      && !mode_r.loopback && !mode_r.internal_loop |=> LOOP_MODE == MMSR_LOOP_INTERNAL)
      else $error("port internal loop not decoded");
   transmitter_on_a: assert property (START_REQUEST && !STOPPED && !SOFT_RESET      // RL17
      |=> TRANSMITTER_ON == !$past(mode_r.transmit_disable))
      else $error("transmitter_on wrong after start");
   receiver_on_a: assert property (START_REQUEST && !STOPPED && !SOFT_RESET      // RL18
      |=> RECEIVER_ON == !$past(mode_r.receive_disable))
      else $error("receiver_on wrong after start");
   alias_a: assert property (wr_commit && sel == 3'h3 && AVS_BYTEENABLE[1:0] == 2'h3 // RL19
      |=> INIT_ADDR_LOW == $past(AVS_WRITEDATA[15:0]))
      else $error("low alias write not stored");
   answer_a: assert property ((AVS_READ || AVS_WRITE) && wait_r |=> !AVS_WAITREQUEST)
      else $error("request not answered in one cycle");

   // ----------------------------------------------------------
   // field checks: a committed write lands bit for bit unless outranked
   // ----------------------------------------------------------
   accept_wr_a: assert property (wr_commit && sel == 3'h2 && AVS_BYTEENABLE[1] // RL7
      && !SOFT_RESET && !INIT_BLOCK.load
      |=> MODE.accept_all_frames == $past(AVS_WRITEDATA[15]))
      else $error("accept-all bit not stored");
   bcast_wr_a: assert property (wr_commit && sel == 3'h2 && AVS_BYTEENABLE[1] // RL8
      && !SOFT_RESET && !INIT_BLOCK.load
      |=> MODE.broadcast_reject == $past(AVS_WRITEDATA[14]))
      else $error("broadcast reject bit not stored");
   own_rej_a: assert property (wr_commit && sel == 3'h2 && AVS_BYTEENABLE[1] // RL9
      && !SOFT_RESET && !INIT_BLOCK.load
      |=> MODE.own_address_reject == $past(AVS_WRITEDATA[13]))
      else $error("own address reject bit not stored");
   port_wr_a: assert property (wr_commit && sel == 3'h2 && AVS_BYTEENABLE[1:0] == 2'h3 // RL10
      && !SOFT_RESET && !INIT_BLOCK.load
      |=> MODE.port_selection == $past(AVS_WRITEDATA[8:7]))
      else $error("port selection not stored");
   rsvd_rd_a: assert property (AVS_READ && wait_r |=> AVS_READDATA[31:16] == 16'h0000) // RL21
      else $error("upper read half not zero");
   rsvd_mode_a: assert property (MODE.rsvd == 4'h0)                        // RL21
      else $error("reserved mode bits stored");
   stop_keep_a: assert property ($rose(STOPPED) && !SOFT_RESET             // RL8 RL15
      && !INIT_BLOCK.load && !wr_commit
      |=> $stable(mode_r))
      else $error("mode changed on entry to stop");
   fdx_on_a: assert property (mode_r.loopback |=> FULL_DUPLEX_TEST)        // RL15
      else $error("loopback without full duplex test");
   fdx_off_a: assert property (!mode_r.loopback |=> !FULL_DUPLEX_TEST)     // RL15
      else $error("full duplex test without loopback");
   retry_full_a: assert property (!mode_r.no_retry ##1 !mode_r.no_retry    // RL11
      |-> TX_ATTEMPT_LIMIT == ATTEMPTS_RTRY && TX_PROTECT_HEAD)
      else $error("attempt limit wrong with retries on");
   fcs_on_a: assert property (!mode_r.fcs_suppress |=> APPEND_FCS)         // RL13
      else $error("FCS dropped without suppress");
   fcs_off_a: assert property (mode_r.fcs_suppress                         // RL13
      && !FRAME_INFO.descriptor_fcs_request
      && !(FRAME_INFO.auto_transmit_pad && FRAME_INFO.short_frame)
      |=> !APPEND_FCS)
      else $error("FCS sent while suppressed");
   fcs_desc_a: assert property (FRAME_INFO.descriptor_fcs_request          // RL13
      && FRAME_INFO.end_of_packet_flag |=> APPEND_FCS)
      else $error("descriptor FCS request ignored");
   stop_off_a: assert property (STOPPED |=> !TRANSMITTER_ON && !RECEIVER_ON) // RL17 RL18
      else $error("on flags survive stop");
   alias_hi_a: assert property (wr_commit && sel == 3'h4 && AVS_BYTEENABLE[1:0] == 2'h3 // RL20
      |=> INIT_ADDR_HIGH == $past(AVS_WRITEDATA[15:0]))
      else $error("high alias write not stored");
   sta_wr_a: assert property (wr_commit && sel == 3'h1 && AVS_BYTEENABLE[1:0] == 2'h3 // RL3
      && !CFG_MEM_VALID && !INIT_BLOCK.load
      |=> STATION_ADDRESS_HIGH == $past(AVS_WRITEDATA[15:0]))
      else $error("station word write not stored");
   sta_init_a: assert property (INIT_BLOCK.load && !CFG_MEM_VALID          // RL3
      |=> STATION_ADDRESS_HIGH == $past(INIT_BLOCK.station_high))
      else $error("station word not loaded from init block");
   reload_a: assert property (CONFIG_MEMORY_RELOAD |=> CFG_MEM_REQ)        // RL1
      else $error("reload did not request config memory");
   loop_int_a: assert property (mode_r.port_selection == PORT_SERIAL       // RL16
      && mode_r.loopback && mode_r.internal_loop && !PORT_INTERNAL_LOOP
      |=> LOOP_MODE == MMSR_LOOP_INTERNAL)
      else $error("serial internal loop not decoded");
   loop_ext_a: assert property (mode_r.port_selection[1] && mode_r.loopback // RL16
      && !mode_r.internal_loop && !PORT_INTERNAL_LOOP
      |=> LOOP_MODE == MMSR_LOOP_EXTERNAL)
      else $error("external loop not decoded");
   rd_open_a: assert property (AVS_READ && wait_r && access_ok && sel == 3'h2 // RL5
      |=> AVS_READDATA == {16'h0000, $past(MODE)})
      else $error("mode read returned wrong data");

   mode_wr_c: cover property (wr_commit && sel == 3'h2);
   cfg_load_c: cover property (CFG_MEM_VALID);
   int_loop_c: cover property (FORCE_COLLISION);
   locked_wr_c: cover property (AVS_WRITE && !wait_r && !access_ok);
   start_on_c: cover property (START_REQUEST && !STOPPED);
endmodule : mmsr_regs

/* File: pkg/mmsr_pkg.sv */
// Summary of operation
// [RL1] station high word loads from config memory after reset and on reload
// [RL2] without config memory the station high word stays undefined
// [RL3] station high word also loads from init block or software write
// [RL4] station address survives hard reset, soft reset and stop
// [RL5] registers accessible only while stopped or suspended
// [RL6] mode fields load from init block or software write
// [RL7] bit 15 set accepts every frame
// [RL8] bit 14 rejects broadcasts; cleared by hard or soft reset
// [RL9] bit 13 disables own address matching
// [RL10] bits 8-7 select port: 11 media independent, 10 serial; reset clears
// [RL11] no_retry clear gives 16 attempts; set gives one, no 64-byte protection
// [RL12] forced collision collides every internal loopback attempt only
// [RL13] fcs_suppress drops FCS unless the descriptor requests one
// [RL14] with auto padding, frames under 64 bytes always carry FCS
// [RL15] loopback gives full duplex test, overrides duplex; reset clears
// [RL16] loopback decode per port: internal, external or normal
// [RL17] transmit_disable blocks transmit ring; else start sets transmitter_on
// [RL18] receive_disable blocks receive ring; else start sets receiver_on
// [RL19] low alias shares storage with init_addr_low
// [RL20] high alias shares storage with init_addr_high
// [RL21] reserved bits written as zero, read here as zero
// [RL22] writes while running are ignored
package mmsr_pkg;
   localparam logic [7:0]  OFS_STA_HI    = 8'h38;
   localparam logic [7:0]  OFS_MODE      = 8'h3C;
   localparam logic [7:0]  OFS_IADR_LO   = 8'h40;
   localparam logic [7:0]  OFS_IADR_HI   = 8'h44;
   localparam logic [15:0] MODE_WR_MASK  = 16'hE1FF;
   localparam logic [15:0] MODE_RST      = 16'h0000;
   localparam logic [15:0] MODE_SRST_CLR = 16'h4184;
   localparam logic [1:0]  PORT_MII      = 2'h3;
   localparam logic [1:0]  PORT_SERIAL   = 2'h2;
   localparam logic [4:0]  ATTEMPTS_RTRY = 5'h10;
   localparam logic [4:0]  ATTEMPTS_ONE  = 5'h01;
   typedef enum logic [1:0] {
      MMSR_LOOP_NORMAL   = 2'b00,
      MMSR_LOOP_INTERNAL = 2'b01,
      MMSR_LOOP_EXTERNAL = 2'b10
   } mmsr_loop_t;
   typedef struct packed {
      logic       accept_all_frames;
      logic       broadcast_reject;
      logic       own_address_reject;
      logic [3:0] rsvd;
      logic [1:0] port_selection;
      logic       internal_loop;
      logic       no_retry;
      logic       forced_collision;
      logic       fcs_suppress;
      logic       loopback;
      logic       transmit_disable;
      logic       receive_disable;
   } mmsr_mode_t;
   typedef struct packed {
      logic        load;
      logic [15:0] station_high;
      mmsr_mode_t  mode;
   } mmsr_init_t;
   typedef struct packed {
      logic descriptor_fcs_request;
      logic end_of_packet_flag;
      logic auto_transmit_pad;
      logic short_frame;
   } mmsr_frame_t;
endpackage : mmsr_pkg
